/* host_port_model.sv */
// host processor model driving the parallel control port
`timescale 1ns/100ps

module host_port_model
    import paged_register_pkg::*;
(
    input wire logic clk,
    input wire logic twoStrobe,
    input wire logic [DATA_W-1:0] busData,
    input wire logic hostDataOe,
    output logic [ADDR_W-1:0] hostAddr,
    output logic [DATA_W-1:0] hostDrive,
    output logic hostReadN,
    output logic hostWriteN,
    output logic hostChipEnableN,
    output logic timedOut
);
    initial
    begin
        hostAddr = '0;
        hostDrive = '0;
        hostReadN = 1'b1;
        hostWriteN = 1'b1;
        hostChipEnableN = 1'b1;
        timedOut = 1'b0;
    end

    // released address and data lines show the inverse of their last value
    task automatic release_bus;
        hostChipEnableN = 1'b1;
        hostWriteN = 1'b1;
        hostReadN = !twoStrobe;
        hostAddr = ~hostAddr;
        hostDrive = ~hostDrive;
    endtask

    task automatic write_word(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk);
        hostAddr = a;
        hostDrive = d;
        hostReadN = !twoStrobe;
        hostChipEnableN = 1'b0;
        hostWriteN = 1'b0;
        repeat (4) @(negedge clk);
        release_bus();
        repeat (8) @(negedge clk);
    endtask

    task automatic read_word(input logic [5:0] a, output logic [15:0] d);
        int n;
        @(negedge clk);
        hostAddr = a;
        hostReadN = 1'b0;
        hostChipEnableN = 1'b0;
        n = 0;
        while (hostDataOe !== 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        timedOut = (n == 10);
        @(negedge clk);
        d = busData;
        release_bus();
        repeat (6) @(negedge clk);
    endtask
endmodule

/* page_region_decoder.sv */
// maps a page value onto channel, region and upper half
`timescale 1ns/100ps

module page_region_decoder
    import paged_register_pkg::*;
#(
    parameter int NUM_CHANNELS = CHANNEL_COUNT
)
(
    input wire logic [15:0] page,
    output logic pageValid,
    output region_type region,
    output logic [CHAN_W-1:0] channel,
    output logic upperHalf
);

    logic [15:0] offset;
    logic [15:0] base;

    always_comb
    begin
        offset = page & (CHANNEL_STRIDE - 16'h0001);
        base = offset & ~UPPER_HALF_PAGE;
        channel = page[CHAN_SHIFT +: CHAN_W];
        upperHalf = (offset & UPPER_HALF_PAGE) != 16'h0000;
        case (base)
            PROG_FILTER_LSB_PAGE: region = REGION_PROG_FILTER_LSB;
            PROG_FILTER_MSB_PAGE: region = REGION_PROG_FILTER_MSB;
            COMP_FILTER_LSB_PAGE: region = REGION_COMP_FILTER_LSB;
            COMP_FILTER_MSB_PAGE: region = REGION_COMP_FILTER_MSB;
            CTRL_PAGE: region = REGION_CTRL;
            default: region = REGION_NONE;
        endcase
        // channel windows repeat every stride; pages beyond the last channel are unmapped
        pageValid = (region != REGION_NONE)
            && ((page >> CHAN_SHIFT) < 16'(NUM_CHANNELS));
    end

endmodule

/* paged_register_address_decoder.sv */
// host port and paged address decoder for the control register space
`timescale 1ns/100ps
//
// Summary of operation
// - high top bit: low bits pick global register
// - address 0x21 reaches the page register
// - low top bit: page plus address bits
// - five low bits pick one of 32
// - channel zero programmable filter low bits pages
// - channel zero programmable filter high bits pages
// - channel zero compensating filter pages
// - control words at pages 0x100, 0x120
// - each channel repeats layout every 0x200
// - page write holds until next rewrite
// - three-strobe and two-strobe modes both work

module paged_register_address_decoder
    import paged_register_pkg::*;
#(
    parameter int NUM_CHANNELS = CHANNEL_COUNT
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] hostAddr,
    input wire logic [DATA_W-1:0] hostDataIn,
    output logic [DATA_W-1:0] hostDataOut,
    output logic hostDataOe,
    input wire logic hostReadN,
    input wire logic hostWriteN,
    input wire logic hostChipEnableN,
    output logic regWrite,
    output logic regRead,
    output logic regGlobal,
    output logic [15:0] regAddr,
    output region_type regRegion,
    output logic [CHAN_W-1:0] regChannel,
    output logic regUpperHalf,
    output logic [WORD_W-1:0] regWord,
    output logic [DATA_W-1:0] regWriteData,
    input wire logic [DATA_W-1:0] regReadData
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] addrMeta_reg, addrSync_reg, addrLast_reg, addrUse;
    logic [DATA_W-1:0] dataMeta_reg, dataSync_reg, dataLast_reg;
    logic [2:0] strobeMeta_reg, strobeSync_reg;
    logic ceNLast_reg, wrNLast_reg, readLast_reg, writeSeen_reg;
    logic ceNSync, wrNSync, rdNSync;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            addrMeta_reg <= '0;
            addrSync_reg <= '0;
            dataMeta_reg <= '0;
            dataSync_reg <= '0;
            addrLast_reg <= '0;
            dataLast_reg <= '0;
            strobeMeta_reg <= 3'h7;
            strobeSync_reg <= 3'h7;
        end
        else
        begin
            addrMeta_reg <= hostAddr;
            addrSync_reg <= addrMeta_reg;
            dataMeta_reg <= hostDataIn;
            dataSync_reg <= dataMeta_reg;
            addrLast_reg <= addrSync_reg;
            dataLast_reg <= dataSync_reg;
            strobeMeta_reg <= {hostChipEnableN, hostWriteN, hostReadN};
            strobeSync_reg <= strobeMeta_reg;
        end
    end

    assign ceNSync = strobeSync_reg[2];
    assign wrNSync = strobeSync_reg[1];
    assign rdNSync = strobeSync_reg[0];

    // ------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------
    logic writeEdge, readActive, readStart, writeSeen_next;

    always_comb
    begin
        // write is taken on the rising write strobe while chip enable was low
        writeEdge = wrNSync && !wrNLast_reg && !ceNLast_reg;
        // with read tied low, no read until chip enable lifts after a write
        writeSeen_next = !ceNSync && (writeSeen_reg || !wrNSync);
        readActive = !ceNSync && !rdNSync && wrNSync && !writeSeen_reg;
        readStart = readActive && !readLast_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ceNLast_reg <= 1'b1;
            wrNLast_reg <= 1'b1;
            readLast_reg <= 1'b0;
            writeSeen_reg <= 1'b0;
        end
        else
        begin
            ceNLast_reg <= ceNSync;
            wrNLast_reg <= wrNSync;
            readLast_reg <= readActive;
            writeSeen_reg <= writeSeen_next;
        end
    end

    // ------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------
    logic [15:0] page_reg, page_next;
    logic isGlobal, isPageAddr, pageValid, upperHalf, mapped;
    logic [WORD_W-1:0] lowWordAddress;
    logic [CHAN_W-1:0] channel;
    logic [15:0] fullAddr;
    region_type region;

    page_region_decoder #(
        .NUM_CHANNELS(NUM_CHANNELS)
    ) pageDecoder (
        .page(page_reg),
        .pageValid(pageValid),
        .region(region),
        .channel(channel),
        .upperHalf(upperHalf)
    );

    always_comb
    begin
        // pins may move as the write strobe lifts, so a write uses the cycle before
        addrUse = writeEdge ? addrLast_reg : addrSync_reg;
        isGlobal = addrUse[ADDR_W-1];
        lowWordAddress = addrUse[WORD_W-1:0];
        isPageAddr = addrUse == PAGE_SELECT_ADDR;
        // global space ignores the page completely
        fullAddr = isGlobal ? {11'h000, lowWordAddress}
            : (page_reg | {11'h000, lowWordAddress});
        // page low bits must be clear for a documented window
        mapped = isGlobal || (pageValid && page_reg[WORD_W-1:0] == 5'h00);
        page_next = (writeEdge && isPageAddr) ? dataLast_reg : page_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            page_reg <= PAGE_SELECT_RESET;
        end
        else
        begin
            page_reg <= page_next;
        end
    end

    // ------------------------------------------------------------
    // register-side strobes and host read data
    // ------------------------------------------------------------
    logic regWrite_next, regRead_next, hostDataOe_next;
    logic [DATA_W-1:0] hostDataOut_next;

    always_comb
    begin
        // unmapped pages get no strobe; the page register itself stays local
        regWrite_next = writeEdge && mapped && !isPageAddr;
        regRead_next = readStart && mapped && !isPageAddr;
        hostDataOe_next = readActive;
        hostDataOut_next = '0;
        if (readActive && isPageAddr)
        begin
            hostDataOut_next = page_reg;
        end
        else if (readActive && mapped)
        begin
            hostDataOut_next = regReadData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            regWrite <= 1'b0;
            regRead <= 1'b0;
            regGlobal <= 1'b0;
            regAddr <= '0;
            regRegion <= REGION_NONE;
            regChannel <= '0;
            regUpperHalf <= 1'b0;
            regWord <= '0;
            regWriteData <= '0;
            hostDataOut <= '0;
            hostDataOe <= 1'b0;
        end
        else
        begin
            regWrite <= regWrite_next;
            regRead <= regRead_next;
            regGlobal <= isGlobal;
            regAddr <= fullAddr;
            regRegion <= isGlobal ? REGION_NONE : region;
            regChannel <= isGlobal ? 3'h0 : channel;
            regUpperHalf <= !isGlobal && upperHalf;
            regWord <= lowWordAddress;
            regWriteData <= dataLast_reg;
            hostDataOut <= hostDataOut_next;
            hostDataOe <= hostDataOe_next;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_page_write;
        writeEdge && isPageAddr;
    endsequence

    property p_global_ignores_page;
        regWrite && regGlobal |-> regAddr[15:5] == 11'h000 && regRegion == REGION_NONE;
    endproperty
    a_global_ignores_page: assert property (p_global_ignores_page)
        else $error("global access carried page bits");
    property p_page_write;
        s_page_write |=> page_reg == $past(dataLast_reg) && !regWrite;
    endproperty
    a_page_write: assert property (p_page_write)
        else $error("page register write not taken");
    property p_paged_addr;
        regWrite && !regGlobal |-> regAddr == (page_reg | {11'h000, regWord});
    endproperty
    a_paged_addr: assert property (p_paged_addr)
        else $error("paged address not page plus word");
    property p_word_follows_pins;
        writeEdge |=> regWord == $past(addrLast_reg[4:0]);
    endproperty
    a_word_follows_pins: assert property (p_word_follows_pins)
        else $error("word select lost");
    property p_ch0_prog_filter;
        regWrite && !regGlobal && regAddr[15:5] == 11'h002 |->
            regRegion == REGION_PROG_FILTER_MSB && !regUpperHalf && regChannel == 3'h0;
    endproperty
    a_ch0_prog_filter: assert property (p_ch0_prog_filter)
        else $error("page 0x40 not filter high bits");
    property p_ctrl_upper;
        regWrite && !regGlobal && regAddr[8:5] == 4'h9 |->
            regRegion == REGION_CTRL && regUpperHalf;
    endproperty
    a_ctrl_upper: assert property (p_ctrl_upper)
        else $error("page 0x120 not upper control words");
    property p_channel_stride;
        regWrite && !regGlobal |-> regChannel == regAddr[11:9];
    endproperty
    a_channel_stride: assert property (p_channel_stride)
        else $error("channel does not follow page stride");
    property p_page_holds;
        !(writeEdge && isPageAddr) |=> $stable(page_reg);
    endproperty
    a_page_holds: assert property (p_page_holds)
        else $error("page changed without a page write");
    property p_unmapped_silent;
        writeEdge && !mapped |=> !regWrite ##1 !regWrite;
    endproperty
    a_unmapped_silent: assert property (p_unmapped_silent)
        else $error("unmapped write produced a strobe");
    property p_unmapped_read_zero;
        readActive && !mapped |=> hostDataOe && hostDataOut == 16'h0000;
    endproperty
    a_unmapped_read_zero: assert property (p_unmapped_read_zero)
        else $error("unmapped read returned data");
    property p_no_drive_in_write;
        !wrNSync |=> !hostDataOe;
    endproperty
    a_no_drive_in_write: assert property (p_no_drive_in_write)
        else $error("bus driven during write strobe");
    property p_single_strobe;
        regWrite |-> !regRead;
    endproperty
    a_single_strobe: assert property (p_single_strobe)
        else $error("read and write strobes together");

endmodule

/* paged_register_pkg.sv */
// constants and types shared by the paged register address decoder
package paged_register_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int WORD_W = 5;
    localparam int CHAN_W = 3;

    // six-bit host address of the page register
    localparam logic [5:0] PAGE_SELECT_ADDR = 6'h21;
    localparam logic [15:0] PAGE_SELECT_RESET = 16'h0000;

    // page layout inside one channel window
    localparam logic [15:0] PROG_FILTER_LSB_PAGE = 16'h0000;
    localparam logic [15:0] PROG_FILTER_MSB_PAGE = 16'h0040;
    localparam logic [15:0] COMP_FILTER_LSB_PAGE = 16'h0080;
    localparam logic [15:0] COMP_FILTER_MSB_PAGE = 16'h00c0;
    localparam logic [15:0] CTRL_PAGE = 16'h0100;
    localparam logic [15:0] UPPER_HALF_PAGE = 16'h0020;
    localparam logic [15:0] CHANNEL_STRIDE = 16'h0200;
    localparam int CHAN_SHIFT = 9;
    localparam int CHANNEL_COUNT = 8;

    typedef enum logic [2:0]
    {
        REGION_PROG_FILTER_LSB = 3'b000,
        REGION_PROG_FILTER_MSB = 3'b001,
        REGION_COMP_FILTER_LSB = 3'b010,
        REGION_COMP_FILTER_MSB = 3'b011,
        REGION_CTRL = 3'b100,
        REGION_NONE = 3'b111
    } region_type;

endpackage

/* tb.sv */
// self-checking testbench for the paged register address decoder
`timescale 1ns/100ps

module tb;
    import paged_register_pkg::*;
    logic clk, resetn, twoStrobe, timedOut, hostDataOe, hostReadN, hostWriteN;
    logic hostChipEnableN, regWrite, regRead, regGlobal, regUpperHalf;
    logic [ADDR_W-1:0] hostAddr;
    logic [DATA_W-1:0] hostDrive, busData, hostDataOut, regWriteData, regReadData;
    logic [15:0] regAddr, capRead;
    region_type regRegion;
    logic [CHAN_W-1:0] regChannel;
    logic [WORD_W-1:0] regWord;
    logic [44:0] capWrite;
    int writes = 0, reads = 0, errTotal = 0, samplesChecked = 0;

    assign busData = hostDataOe ? hostDataOut : hostDrive;
    // register file stand-in: read data follows the address
    assign regReadData = regAddr ^ 16'h5a5a;

    paged_register_address_decoder DUT (.clk(clk), .resetn(resetn), .hostAddr(hostAddr),
        .hostDataIn(busData), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .hostReadN(hostReadN), .hostWriteN(hostWriteN), .hostChipEnableN(hostChipEnableN),
        .regWrite(regWrite), .regRead(regRead), .regGlobal(regGlobal), .regAddr(regAddr),
        .regRegion(regRegion), .regChannel(regChannel), .regUpperHalf(regUpperHalf),
        .regWord(regWord), .regWriteData(regWriteData), .regReadData(regReadData));

    host_port_model host (.clk(clk), .twoStrobe(twoStrobe), .busData(busData),
        .hostDataOe(hostDataOe), .hostAddr(hostAddr), .hostDrive(hostDrive),
        .hostReadN(hostReadN), .hostWriteN(hostWriteN), .hostChipEnableN(hostChipEnableN),
        .timedOut(timedOut));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (regWrite === 1'b1)
        begin
            writes++;
            capWrite <= {regGlobal, regAddr, regRegion, regChannel, regUpperHalf, regWord,
                regWriteData};
        end
        if (regRead === 1'b1)
        begin
            reads++;
            capRead <= regAddr;
        end
    end

    task automatic completeRun;
        $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [44:0] got, input logic [44:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        host.read_word(a, d);
        if (timedOut)
        begin
            errTotal++;
            completeRun();
        end
    endtask

    task automatic reset_state;
        logic [15:0] d;
        check(45'(hostDataOe), 45'h0);
        rd(6'h21, d);
        check(45'(d), 45'h0);
    endtask

    task automatic global_space;
        logic [15:0] d;
        int n;
        host.write_word(6'h21, 16'h0240);
        n = reads + writes;
        rd(6'h21, d);
        check(45'(d), 45'h0240);
        check(45'(reads + writes), 45'(n));
        host.write_word(6'h25, 16'h1234);
        check(capWrite, {1'b1, 16'h0005, REGION_NONE, 3'h0, 1'b0, 5'h05, 16'h1234});
        rd(6'h30, d);
        check(45'(d), 45'(16'h0010 ^ 16'h5a5a));
        rd(6'h21, d);
        check(45'(d), 45'h0240);
    endtask

    task automatic region_map;
        int chans[3] = '{0, 1, 7};
        logic [15:0] page, data;
        logic [4:0] w;
        int n;
        foreach (chans[c])
        begin
            for (int i = 0; i < 10; i++)
            begin
                page = 16'(chans[c] * 16'h0200 + i * 16'h0020);
                w = 5'(i * 3 + chans[c]);
                data = 16'(chans[c] * 16'h1111) ^ 16'(i);
                host.write_word(6'h21, page);
                n = writes;
                host.write_word({1'b0, w}, data);
                check(45'(writes), 45'(n + 1));
                check(capWrite, {1'b0, page | 16'(w), region_type'(3'(i / 2)),
                    3'(chans[c]), 1'(i), w, data});
            end
        end
    endtask

    task automatic paged_read;
        logic [15:0] d;
        int n;
        host.write_word(6'h21, 16'h0720);
        n = reads;
        rd(6'h1f, d);
        check(45'(d), 45'(16'h073f ^ 16'h5a5a));
        check(45'(capRead), 45'h073f);
        check(45'(reads), 45'(n + 1));
    endtask

    task automatic unmapped;
        logic [15:0] pages[2] = '{16'h0010, 16'h1000};
        logic [15:0] d;
        int n;
        foreach (pages[p])
        begin
            host.write_word(6'h21, pages[p]);
            n = reads + writes;
            host.write_word(6'h03, 16'hffff);
            rd(6'h03, d);
            check(45'(d), 45'h0);
            check(45'(reads + writes), 45'(n));
        end
    endtask

    task automatic two_strobe;
        logic [15:0] d;
        twoStrobe = 1'b1;
        host.write_word(6'h21, 16'h0e00);
        host.write_word(6'h1f, 16'hbeef);
        check(capWrite, {1'b0, 16'h0e1f, REGION_PROG_FILTER_LSB, 3'h7, 1'b0, 5'h1f,
            16'hbeef});
        rd(6'h1f, d);
        check(45'(d), 45'(16'h0e1f ^ 16'h5a5a));
        rd(6'h21, d);
        check(45'(d), 45'h0e00);
        twoStrobe = 1'b0;
    endtask

    initial
    begin
        resetn = 1'b0;
        twoStrobe = 1'b0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        reset_state();
        global_space();
        region_map();
        paged_read();
        unmapped();
        two_strobe();
        completeRun();
    end
endmodule
